//--- logic/edoc_pkg.sv
// Constants for the extended-output page mode memory controller.
// Assumes one 200 MHz clock and the slower of the two memory speed grades.
package edoc_pkg;

    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 5000;

    // Memory timing figures, in ns unless named otherwise
    localparam int T_RAS_NS      = 60;     // Row active, least
    localparam int T_RASP_NS     = 100000; // Row active in page mode, most
    localparam int T_RP_NS       = 40;     // Row precharge, least
    localparam int T_CP_NS       = 10;     // Column precharge, least
    localparam int T_RCD_NS      = 20;     // Row to column strobe, least
    localparam int T_RAC_NS      = 60;     // Access from row strobe
    localparam int T_CAC_NS      = 15;     // Access from column strobe
    localparam int T_AA_NS       = 30;     // Access from column address
    localparam int T_CAS_NS      = 10;     // Column strobe pulse, least
    localparam int T_DH_NS       = 15;     // Write data hold, least
    localparam int T_CSR_NS      = 5;      // Column setup before row strobe
    localparam int T_CHR_NS      = 10;     // Column hold after row strobe
    localparam int T_REF_MS      = 16;     // Whole refresh period
    localparam int REF_ROWS      = 1024;   // Refresh cycles per period
    localparam int T_POWERUP_US  = 200;    // Pause after supply
    localparam int INIT_CYCLES   = 8;      // Wake-up row strobe cycles

    // Widths
    localparam int TMR_W  = 16;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;

    // Read wait after column strobe: latest of the access limits
    localparam int RD_WAIT_NS =
        (T_AA_NS > T_CAC_NS) ?
        ((T_AA_NS > T_RAC_NS - T_RCD_NS) ? T_AA_NS : T_RAC_NS - T_RCD_NS) :
        ((T_CAC_NS > T_RAC_NS - T_RCD_NS) ? T_CAC_NS : T_RAC_NS - T_RCD_NS);
    localparam int WR_WAIT_NS = (T_DH_NS > T_CAS_NS) ? T_DH_NS : T_CAS_NS;

    // Least times round up to whole cycles
    localparam int RAS_CYC = (T_RAS_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int RP_CYC  = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int CP_CYC  = (T_CP_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int RCD_CYC = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int CSR_CYC = (T_CSR_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int CHR_CYC = (T_CHR_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    // One extra cycle covers the capture flop setup
    localparam int RD_CYC  = (RD_WAIT_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS + 1;
    localparam int WR_CYC  = (WR_WAIT_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
    localparam int POWERUP_CYC = (T_POWERUP_US * 1000 * 1000
                                  + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Longest times round down
    localparam int REFI_CYC  = (T_REF_MS * 1000000 / REF_ROWS) * 1000
                               / CLK_PERIOD_PS;
    localparam int RASP_CYC  = T_RASP_NS * 1000 / CLK_PERIOD_PS;

    // Reset values
    localparam logic [3:0] INIT_CNT_RST = 4'h8;

    // Controller states, one-hot
    typedef enum logic [10:0] {
        ST_PWRUP    = 11'h001,
        ST_IDLE     = 11'h002,
        ST_ROW      = 11'h004,
        ST_COL      = 11'h008,
        ST_CASHI    = 11'h010,
        ST_OPEN     = 11'h020,
        ST_CBR_CAS  = 11'h040,
        ST_CBR_RAS  = 11'h080,
        ST_CBR_HOLD = 11'h100,
        ST_PRE      = 11'h200,
        ST_SPARE    = 11'h400
    } edoc_state_e;

endpackage : edoc_pkg

//--- logic/edoc_timer.sv
// Down-counting interval timer used for every wait of the controller.
// Assumes a synchronous, active high reset on the shared clock.
`timescale 1ns/1ps
`default_nettype none

module edoc_timer #(
    parameter int               W       = 16,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           clk_i,
    input  wire logic           srst_i,
    input  wire logic           load_i,
    input  wire logic [W-1:0]   value_i,
    output logic                done_o
);

    logic [W-1:0] count;

    // Load starts a wait; done after value_i cycles
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            count <= RST_VAL;
        else if (load_i)
            count <= value_i;
        else if (count != '0)
            count <= count - W'(1);
    end

    assign done_o = (count == '0);

endmodule : edoc_timer

`default_nettype wire

//--- logic/edoc_ctrl.sv
// Host-side controller for a 1M x 16 extended-output page mode memory.
// Assumes the memory pins are registered off-chip with no extra delay
// and the data lines are resolved from data_lines_oe_n_o by the board.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - A cycle starts at row strobe low, ends with both strobes high.
// - Row strobe stays low at least the least row-active time.
// - New cycle waits for row and column precharge times.
// - Column address held long enough after the row strobe in reads.
// - Write data is valid by the first strobe or write enable fall.
// - 1,024 refresh cycles are issued within every 16 ms.
// - Wait 200 us after supply, then at least eight refresh cycles.
// - Row strobe held high during power-on.
// - Repeat the eight-cycle wake-up if refresh falls overdue.
// - Column-first refresh needs a byte column strobe low.
module edoc_ctrl #(
    parameter int unsigned PWRUP_CYC = edoc_pkg::POWERUP_CYC,
    parameter int unsigned RASP_CYC  = edoc_pkg::RASP_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // User request port
    input  wire logic        req_valid_i,
    input  wire logic        req_write_i,
    input  wire logic [19:0] req_addr_i,
    input  wire logic [15:0] req_wdata_i,
    input  wire logic [1:0]  req_be_i,
    output logic             req_ready_o,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_rdata_o,
    output logic             init_done_o,
    // Memory pins
    output logic             row_strobe_n_o,
    output logic             low_byte_column_strobe_n_o,
    output logic             high_byte_column_strobe_n_o,
    output logic             write_enable_n_o,
    output logic             output_enable_n_o,
    output logic [9:0]       mux_address_inputs_o,
    output logic [15:0]      data_lines_o,
    output logic             data_lines_oe_n_o,
    input  wire logic [15:0] data_lines_i
);

    edoc_pkg::edoc_state_e state;
    edoc_pkg::edoc_state_e next_state;

    logic        pending;
    logic        next_pending;
    logic        accept;
    logic        consume;
    logic        start_ref;
    logic        ref_due;
    logic        ref_miss;
    logic [3:0]  init_cnt;
    logic [9:0]  cur_row;
    logic [9:0]  cur_col;
    logic        cur_we;
    logic [15:0] cur_wdata;
    logic [1:0]  cur_be;
    logic [9:0]  open_row;
    logic        op_we;
    logic [1:0]  op_be;
    logic        row_hit;
    logic        tm_load;
    logic [15:0] tm_val;
    logic        tm_done;
    logic        ras_done;
    logic        pre_done;
    logic        page_done;
    logic        refi_done;
    logic        ras_fall;

    edoc_timer #(.W(16), .RST_VAL(16'(PWRUP_CYC))) u_main_tmr (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .load_i  (tm_load),
        .value_i (tm_val),
        .done_o  (tm_done)
    );

    edoc_timer #(.W(16)) u_ras_tmr (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .load_i  (ras_fall),
        .value_i (16'(edoc_pkg::RAS_CYC)),
        .done_o  (ras_done)
    );

    edoc_timer #(.W(16)) u_pre_tmr (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .load_i  (next_state == edoc_pkg::ST_PRE),
        .value_i (16'(edoc_pkg::RP_CYC)),
        .done_o  (pre_done)
    );

    // Longest page-mode row-active time
    edoc_timer #(.W(16)) u_page_tmr (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .load_i  (ras_fall),
        .value_i (16'(RASP_CYC - edoc_pkg::RD_CYC - edoc_pkg::CP_CYC)),
        .done_o  (page_done)
    );

    // evenly spaced refresh ticks, reloaded on expiry
    edoc_timer #(.W(16)) u_refi_tmr (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .load_i  (refi_done),
        .value_i (16'(edoc_pkg::REFI_CYC - 1)),
        .done_o  (refi_done)
    );

    assign accept   = req_valid_i & req_ready_o;
    assign row_hit  = (cur_row == open_row);
    assign ras_fall = (next_state == edoc_pkg::ST_ROW) |
                      (next_state == edoc_pkg::ST_CBR_RAS);
    assign ref_miss = refi_done & ref_due & ~start_ref;

    // Next state and wait loads
    always_comb
    begin
        next_state = state;
        tm_load    = 1'b0;
        tm_val     = 16'h0000;
        consume    = 1'b0;
        start_ref  = 1'b0;
        case (state)
            edoc_pkg::ST_PWRUP:
                if (tm_done)
                    next_state = edoc_pkg::ST_IDLE;
            edoc_pkg::ST_IDLE:
                // precharge done before the next row strobe
                if (pre_done)
                begin
                    if (ref_due || init_cnt != 4'h0)
                    begin
                        next_state = edoc_pkg::ST_CBR_CAS;
                        tm_load    = 1'b1;
                        tm_val     = 16'(edoc_pkg::CSR_CYC);
                        start_ref  = 1'b1;
                    end
                    else if (pending)
                    begin
                        next_state = edoc_pkg::ST_ROW;
                        tm_load    = 1'b1;
                        tm_val     = 16'(edoc_pkg::RCD_CYC);
                    end
                end
            edoc_pkg::ST_ROW:
                if (tm_done)
                begin
                    next_state = edoc_pkg::ST_COL;
                    tm_load    = 1'b1;
                    tm_val     = cur_we ? 16'(edoc_pkg::WR_CYC)
                                        : 16'(edoc_pkg::RD_CYC);
                    consume    = 1'b1;
                end
            edoc_pkg::ST_COL:
                if (tm_done)
                begin
                    next_state = edoc_pkg::ST_CASHI;
                    tm_load    = 1'b1;
                    tm_val     = 16'(edoc_pkg::CP_CYC);
                end
            edoc_pkg::ST_CASHI:
                // column precharge before the next column strobe
                if (tm_done)
                    next_state = edoc_pkg::ST_OPEN;
            edoc_pkg::ST_OPEN:
                // page hits reuse the open row
                if (ref_due || page_done || (pending && !row_hit))
                begin
                    // row stays active its least time
                    if (ras_done)
                        next_state = edoc_pkg::ST_PRE;
                end
                else if (pending)
                begin
                    // reads and writes mix within the row
                    next_state = edoc_pkg::ST_COL;
                    tm_load    = 1'b1;
                    tm_val     = cur_we ? 16'(edoc_pkg::WR_CYC)
                                        : 16'(edoc_pkg::RD_CYC);
                    consume    = 1'b1;
                end
            edoc_pkg::ST_CBR_CAS:
                if (tm_done)
                begin
                    next_state = edoc_pkg::ST_CBR_RAS;
                    tm_load    = 1'b1;
                    tm_val     = 16'(edoc_pkg::CHR_CYC);
                end
            edoc_pkg::ST_CBR_RAS:
                if (tm_done)
                    next_state = edoc_pkg::ST_CBR_HOLD;
            edoc_pkg::ST_CBR_HOLD:
                if (ras_done)
                    next_state = edoc_pkg::ST_PRE;
            edoc_pkg::ST_PRE:
                next_state = edoc_pkg::ST_IDLE;
            default:
                next_state = edoc_pkg::ST_PRE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            state <= edoc_pkg::ST_PWRUP;
        else
            state <= next_state;
    end

    // Request holding register; one request waits at a time
    assign next_pending = (pending & ~consume) | accept;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pending   <= 1'b0;
            cur_row   <= 10'h000;
            cur_col   <= 10'h000;
            cur_we    <= 1'b0;
            cur_wdata <= 16'h0000;
            cur_be    <= 2'h0;
        end
        else
        begin
            pending <= next_pending;
            if (accept)
            begin
                cur_row   <= req_addr_i[19:10];
                cur_col   <= req_addr_i[9:0];
                cur_we    <= req_write_i;
                cur_wdata <= req_wdata_i;
                cur_be    <= req_be_i;
            end
        end
    end

    // Operation being carried out and its open row
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            op_we    <= 1'b0;
            op_be    <= 2'h0;
            open_row <= 10'h000;
        end
        else
        begin
            if (consume)
            begin
                op_we <= cur_we;
                op_be <= cur_be;
            end
            if (next_state == edoc_pkg::ST_ROW)
                open_row <= cur_row;
        end
    end

    // Refresh bookkeeping; a new tick wins over the clear
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ref_due  <= 1'b0;
            init_cnt <= edoc_pkg::INIT_CNT_RST;
        end
        else
        begin
            if (refi_done)
                ref_due <= 1'b1;
            else if (start_ref)
                ref_due <= 1'b0;
            if (ref_miss)
                init_cnt <= edoc_pkg::INIT_CNT_RST;
            else if (start_ref && init_cnt != 4'h0)
                init_cnt <= init_cnt - 4'h1;
        end
    end

    // Status toward the user
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            init_done_o <= 1'b0;
            req_ready_o <= 1'b0;
        end
        else
        begin
            init_done_o <= (state != edoc_pkg::ST_PWRUP) && (init_cnt == 4'h0);
            req_ready_o <= init_done_o & (init_cnt == 4'h0) & ~next_pending;
        end
    end

    // Memory pins, set from the state being entered
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            // row strobe high from reset onward
            row_strobe_n_o              <= 1'b1;
            low_byte_column_strobe_n_o  <= 1'b1;
            high_byte_column_strobe_n_o <= 1'b1;
            write_enable_n_o            <= 1'b1;
            output_enable_n_o           <= 1'b1;
            mux_address_inputs_o        <= 10'h000;
            data_lines_o                <= 16'h0000;
            data_lines_oe_n_o           <= 1'b1;
        end
        else
        begin
            // row strobe low only inside a cycle
            row_strobe_n_o <= !(next_state == edoc_pkg::ST_ROW ||
                                next_state == edoc_pkg::ST_COL ||
                                next_state == edoc_pkg::ST_CASHI ||
                                next_state == edoc_pkg::ST_OPEN ||
                                next_state == edoc_pkg::ST_CBR_RAS ||
                                next_state == edoc_pkg::ST_CBR_HOLD);
            // both byte strobes low before the row strobe falls
            if (next_state == edoc_pkg::ST_CBR_CAS ||
                next_state == edoc_pkg::ST_CBR_RAS)
            begin
                low_byte_column_strobe_n_o  <= 1'b0;
                high_byte_column_strobe_n_o <= 1'b0;
            end
            // byte strobes follow the byte enables
            else if (next_state == edoc_pkg::ST_COL)
            begin
                low_byte_column_strobe_n_o  <= !(consume ? cur_be[0]
                                                         : op_be[0]);
                high_byte_column_strobe_n_o <= !(consume ? cur_be[1]
                                                         : op_be[1]);
            end
            else
            begin
                low_byte_column_strobe_n_o  <= 1'b1;
                high_byte_column_strobe_n_o <= 1'b1;
            end
            // write enable falls with the column strobe
            // write data driven on the same edge
            // column address held through the whole access
            if (consume)
            begin
                write_enable_n_o     <= !cur_we;
                // output enable low for reads with write high
                output_enable_n_o    <= cur_we;
                mux_address_inputs_o <= cur_col;
                data_lines_o         <= cur_wdata;
                data_lines_oe_n_o    <= !cur_we;
            end
            else if (next_state != edoc_pkg::ST_COL)
            begin
                write_enable_n_o  <= 1'b1;
                output_enable_n_o <= 1'b1;
                data_lines_oe_n_o <= 1'b1;
            end
            // row address presented with the row strobe fall
            if (next_state == edoc_pkg::ST_ROW)
                mux_address_inputs_o <= cur_row;
        end
    end

    // read data sampled once the longest access has passed
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            if (state == edoc_pkg::ST_COL && tm_done && !op_we)
            begin
                rsp_valid_o <= 1'b1;
                rsp_rdata_o <= data_lines_i & {{8{op_be[1]}}, {8{op_be[0]}}};
            end
        end
    end

endmodule : edoc_ctrl

`default_nettype wire

//--- testbench/edoc_ctrl_sva.sv
// Checker of the controller's memory pins and user handshake.
// Assumes it is bound onto edoc_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module edoc_ctrl_sva (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic init_done_o,
    input wire logic row_strobe_n_o,
    input wire logic low_byte_column_strobe_n_o,
    input wire logic high_byte_column_strobe_n_o,
    input wire logic write_enable_n_o,
    input wire logic output_enable_n_o,
    input wire logic data_lines_oe_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // Short names for the strobes and output enable
    wire logic row_n = row_strobe_n_o;
    wire logic lo_n  = low_byte_column_strobe_n_o;
    wire logic hi_n  = high_byte_column_strobe_n_o;
    wire logic oe_n  = output_enable_n_o;
    // Steps of a row cycle and of a read
    sequence s_row_held;
        !row_n [*8] ##1 !row_n [*4];
    endsequence
    sequence s_row_rest;
        row_n [*8];
    endsequence
    sequence s_read_win;
        !oe_n [*8] ##1 !oe_n [*2];
    endsequence
    chk_row_active: assert property (
        $fell(row_n) |-> s_row_held) else $error("row strobe short");
    chk_row_rest: assert property (
        $rose(row_n) |-> s_row_rest) else $error("row precharge short");
    chk_col_rest: assert property (
        $rose(lo_n) |-> lo_n [*2]) else $error("column precharge short");
    chk_cycle_end: assert property (
        $rose(row_n) |-> lo_n && hi_n) else $error("cycle ended early");
    chk_read_we: assert property (
        !oe_n && !(lo_n && hi_n) |-> write_enable_n_o)
        else $error("read with write enable low");
    chk_read_timing: assert property (
        $fell(oe_n) |-> s_read_win ##1 oe_n ##[0:1] rsp_valid_o)
        else $error("read window wrong");
    chk_rsp_pulse: assert property (
        rsp_valid_o |=> !rsp_valid_o) else $error("response too long");
    chk_write_data: assert property (
        ($fell(lo_n) || $fell(hi_n)) && !write_enable_n_o
        |-> !data_lines_oe_n_o) else $error("write data late");
    chk_refresh_entry: assert property (
        $fell(lo_n) && row_n |-> ##2 !row_n && !lo_n)
        else $error("refresh entry wrong");
    chk_refresh_quiet: assert property (
        $fell(row_n) && !(lo_n && hi_n) |-> data_lines_oe_n_o && oe_n)
        else $error("data driven in refresh");
    chk_ready_init: assert property (
        req_ready_o |-> init_done_o) else $error("ready before wake-up");
endmodule : edoc_ctrl_sva

bind edoc_ctrl edoc_ctrl_sva u_sva (
    .clk_i, .srst_i, .req_ready_o, .rsp_valid_o, .init_done_o,
    .row_strobe_n_o, .low_byte_column_strobe_n_o,
    .high_byte_column_strobe_n_o, .write_enable_n_o,
    .output_enable_n_o, .data_lines_oe_n_o
);
`default_nettype wire

//--- testbench/edoc_mem_model.sv
// Behavioural model of the paged memory seen at the controller pins.
// Assumes pins change just after the controller clock edge.
`timescale 1ns/1ps
`default_nettype none
module edoc_mem_model (
    input  wire logic        row_n_i,
    input  wire logic        lo_n_i,
    input  wire logic        hi_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [9:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]      data_o,
    output logic [15:0]      refresh_cnt_o
);
    logic [15:0] mem [int];
    logic [9:0]  row   = 10'h0;
    logic [15:0] rd    = 16'h0;
    logic        refr  = 1'b0;
    logic        lo_en = 1'b0;
    logic        hi_en = 1'b0;
    logic        vld   = 1'b0;
    realtime     t_row = 0;
    int          k;
    // internal strobe from first fall to last rise
    wire logic   col_n = lo_n_i & hi_n_i;
    initial refresh_cnt_o = 16'h0;
    // row open, or refresh from own counter
    always @(negedge row_n_i)
    begin
        #1;
        t_row = $realtime;
        refr = !col_n;
        if (refr) refresh_cnt_o = refresh_cnt_o + 16'h1;
        else row = addr_i;
    end
    // column access, bytes gated by strobes
    always @(negedge col_n)
    begin
        #1;
        if (!row_n_i && !refr)
        begin
            lo_en = !lo_n_i;
            hi_en = !hi_n_i;
            k = {row, addr_i};
            if (!mem.exists(k)) mem[k] = 16'h0;
            if (!we_n_i && lo_en) mem[k][7:0] = wdata_i[7:0];
            if (!we_n_i && hi_en) mem[k][15:8] = wdata_i[15:8];
            rd = mem[k];
        end
    end
    // data valid once column and row access times pass
    always @(negedge col_n)
    begin
        vld = 1'b0;
        #(edoc_pkg::T_AA_NS);
        while ($realtime < t_row + edoc_pkg::T_RAC_NS) #1;
        vld = 1'b1;
    end
    // drive while enabled, held past column rise
    wire logic drv = !row_n_i && !oe_n_i && we_n_i && !refr && vld;
    // Released byte lanes show the inverse of the last word
    assign data_o = {drv && hi_en ? rd[15:8] : ~rd[15:8],
                     drv && lo_en ? rd[7:0] : ~rd[7:0]};
endmodule : edoc_mem_model
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the controller against the memory model.
// Assumes a short power-up count so the wake-up ends quickly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i       = 1'b0;
    logic        srst_i      = 1'b1;
    logic        req_valid_i = 1'b0;
    logic        req_write_i = 1'b0;
    logic [19:0] req_addr_i  = 20'h0;
    logic [15:0] req_wdata_i = 16'h0;
    logic [1:0]  req_be_i    = 2'h0;
    logic        req_ready_o, rsp_valid_o, init_done_o, row_strobe_n_o;
    logic        low_byte_column_strobe_n_o, high_byte_column_strobe_n_o;
    logic        write_enable_n_o, output_enable_n_o, data_lines_oe_n_o;
    logic [9:0]  mux_address_inputs_o;
    logic [15:0] rsp_rdata_o, data_lines_o, mem_data, refresh_cnt;
    wire logic [15:0] data_lines_i;
    wire logic [5:0]  pins = {row_strobe_n_o, low_byte_column_strobe_n_o,
        high_byte_column_strobe_n_o, write_enable_n_o, output_enable_n_o,
        data_lines_oe_n_o};
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    // Controller with a short power-up pause
    edoc_ctrl #(.PWRUP_CYC(50), .RASP_CYC(30)) u_dut (
        .clk_i, .srst_i, .req_valid_i, .req_write_i, .req_addr_i,
        .req_wdata_i, .req_be_i, .req_ready_o, .rsp_valid_o,
        .rsp_rdata_o, .init_done_o, .row_strobe_n_o,
        .low_byte_column_strobe_n_o, .high_byte_column_strobe_n_o,
        .write_enable_n_o, .output_enable_n_o, .mux_address_inputs_o,
        .data_lines_o, .data_lines_oe_n_o, .data_lines_i
    );
    // Memory on the far side of the pins
    edoc_mem_model u_mem (
        .row_n_i(row_strobe_n_o), .lo_n_i(low_byte_column_strobe_n_o),
        .hi_n_i(high_byte_column_strobe_n_o), .we_n_i(write_enable_n_o),
        .oe_n_i(output_enable_n_o), .addr_i(mux_address_inputs_o),
        .wdata_i(data_lines_o), .data_o(mem_data),
        .refresh_cnt_o(refresh_cnt)
    );
    // Shared data lines: controller wins while it drives
    assign data_lines_i = data_lines_oe_n_o ? mem_data : data_lines_o;
    // Clock of 5 ns period
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Cycle ceiling against hangs
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            errors++;
            print_verdict();
        end
    end
    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : compare
    // One request, held until taken
    task automatic send(input logic w, input logic [19:0] a,
                        input logic [15:0] d, input logic [1:0] be);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_write_i <= w;
        req_addr_i  <= a;
        req_wdata_i <= d;
        req_be_i    <= be;
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
    endtask : send
    task automatic rd(input logic [19:0] a, input logic [1:0] be,
                      input logic [15:0] exp);
        send(1'b0, a, 16'h0, be);
        do @(posedge clk_i); while (rsp_valid_o !== 1'b1);
        compare(rsp_rdata_o, exp);
    endtask : rd
    task automatic t_init();
        int n;
        n = 0;
        compare({10'h0, pins}, 16'h3f);
        compare({15'h0, init_done_o}, 16'h0);
        srst_i <= 1'b0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (init_done_o !== 1'b1);
        compare({15'h0, n >= 202}, 16'h1);
        repeat (2) @(posedge clk_i);
        compare({15'h0, refresh_cnt >= 16'h8}, 16'h1);
        $display("test init done");
    endtask : t_init
    task automatic t_page();
        send(1'b1, 20'h00005, 16'h1234, 2'h3);
        send(1'b1, 20'h003ff, 16'hbeef, 2'h3);
        rd(20'h003ff, 2'h3, 16'hbeef);
        rd(20'h00005, 2'h3, 16'h1234);
        send(1'b1, 20'h00005, 16'hab00, 2'h2);
        rd(20'h00005, 2'h3, 16'hab34);
        rd(20'h003ff, 2'h1, 16'h00ef);
        $display("test page done");
    endtask : t_page
    task automatic t_rows();
        send(1'b1, 20'hffc00, 16'h5a5a, 2'h3);
        rd(20'h00005, 2'h3, 16'hab34);
        rd(20'hffc00, 2'h3, 16'h5a5a);
        send(1'b1, 20'h0a0a0, 16'h0f0f, 2'h0);
        rd(20'h0a0a0, 2'h3, 16'h0000);
        $display("test rows done");
    endtask : t_rows
    task automatic t_refresh();
        int c0;
        c0 = refresh_cnt;
        repeat (3125) @(posedge clk_i);
        compare({15'h0, (refresh_cnt - c0) inside {1, 2}}, 16'h1);
        rd(20'hffc00, 2'h3, 16'h5a5a);
        $display("test refresh done");
    endtask : t_refresh
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    // Main sequence, reset held five cycles
    initial
    begin
        repeat (5) @(posedge clk_i);
        t_init();
        t_page();
        t_rows();
        t_refresh();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
